//--- ebsc_regs.vh
// Constants of the external bus strobe controller.
// Assumes inclusion by bare name from the design file.
`ifndef EBSC_REGS_VH
`define EBSC_REGS_VH

// --------------------------------------------------
// Address space codes
// --------------------------------------------------
`define EBSC_SPACE_PROG 2'h0
`define EBSC_SPACE_DATA 2'h1
`define EBSC_SPACE_IO 2'h2

// --------------------------------------------------
// Widths and idle levels
// --------------------------------------------------
`define EBSC_ADDR_W 16
`define EBSC_DATA_W 16
`define EBSC_WS_W 3
`define EBSC_STROBE_IDLE 1'h1
`define EBSC_RW_IDLE 1'h1
`define EBSC_WS_NONE 3'h0

`endif

//--- ebsc_top.v
// External bus strobe controller: space, direction and access strobes.
// Assumes a core request port on i_clk and asynchronous pins that are
// synchronised here before use.
`timescale 1ns/1ps
`include "ebsc_regs.vh"

// Functional notes
// [R1] Test reset high gives scan system control
// [R2] Test reset low means functional mode
// [R3] Space strobes idle high, low on access
// [R4] Read/write high except during writes
// [R5] Write/read is inverse of read/write
// [R6] Read strobe active on every read
// [R7] Write strobe fall starts driving data
// [R8] Write strobe active on every write
// [R9] Access strobe low on every bus cycle
// [R10] Float strobes on off, no test reset, emulator_line_zero
// [R11] Shared general pin is input after reset
// [R12] Not ready: wait one cycle, resample
// [R13] Ready sampled only with wait states set
// [R14] Never more than one space strobe
// [R15] Outputs idle after reset until access
module ebsc_top #(
    parameter AW = `EBSC_ADDR_W,
    parameter DW = `EBSC_DATA_W,
    parameter WW = `EBSC_WS_W
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_req,
    input wire [1:0] i_req_space,
    input wire i_req_write,
    input wire [AW-1:0] i_req_addr,
    input wire [DW-1:0] i_req_wdata,
    input wire [WW-1:0] i_wait_state_control,
    input wire i_port_c_bit_zero_wr_mode,
    input wire i_ready,
    input wire i_test_reset,
    input wire i_emulator_line_zero,
    input wire i_emulator_line_one_output_off,
    input wire [DW-1:0] i_data_in,
    output reg o_busy,
    output reg o_done,
    output reg [DW-1:0] o_rdata,
    output reg o_scan_mode,
    output reg [AW-1:0] o_addr,
    output reg o_addr_oe,
    output reg [DW-1:0] o_data_out,
    output reg o_data_oe,
    output reg o_program_space_strobe_n,
    output reg o_data_space_strobe_n,
    output reg o_io_space_strobe_n,
    output reg o_rw,
    output reg o_wr,
    output reg o_port_c_bit_zero_oe,
    output reg o_rd_n,
    output reg o_we_n,
    output reg o_external_access_strobe_n,
    output reg o_strobe_oe
);

    // --------------------------------------------------
    // States
    // --------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_ACT = 1'b1;

    // --------------------------------------------------
    // Space decode, one-hot low-active
    // --------------------------------------------------
    function [2:0] space_dec;
        input [1:0] sp;
        begin
            case (sp)
                `EBSC_SPACE_PROG: space_dec = 3'b110;
                `EBSC_SPACE_DATA: space_dec = 3'b101;
                `EBSC_SPACE_IO: space_dec = 3'b011;
                default: space_dec = 3'b111;
            endcase
        end
    endfunction

    // --------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------
    // Two stages each; only the second stage is read.
    reg ready_s1;
    reg ready_s2;
    reg trst_s1;
    reg trst_s2;
    reg emulator_line_zero_s1;
    reg emulator_line_zero_s2;
    reg off_s1;
    reg off_s2;
    reg [DW-1:0] din_s1;
    reg [DW-1:0] din_s2;

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ready_s1 <= 1'b1;
            ready_s2 <= 1'b1;
            trst_s1 <= 1'b0;
            trst_s2 <= 1'b0;
            emulator_line_zero_s1 <= 1'b1;
            emulator_line_zero_s2 <= 1'b1;
            off_s1 <= 1'b1;
            off_s2 <= 1'b1;
            din_s1 <= {DW{1'b0}};
            din_s2 <= {DW{1'b0}};
        end
        else
        begin
            ready_s1 <= i_ready;
            ready_s2 <= ready_s1;
            trst_s1 <= i_test_reset;
            trst_s2 <= trst_s1;
            emulator_line_zero_s1 <= i_emulator_line_zero;
            emulator_line_zero_s2 <= emulator_line_zero_s1;
            off_s1 <= i_emulator_line_one_output_off;
            off_s2 <= off_s1;
            din_s1 <= i_data_in;
            din_s2 <= din_s1;
        end
    end

    // --------------------------------------------------
    // Access sequencer
    // --------------------------------------------------
    reg state;
    reg [WW-1:0] ws_cnt;
    reg [WW-1:0] ws_set;
    reg cur_write;
    reg [1:0] fin_pipe;

    wire float_cond = ~off_s2 & ~trst_s2 & emulator_line_zero_s2; // [R10]
    wire scan = trst_s2; // [R1]
    wire accept = (state == ST_IDLE) & i_req & ~o_busy & ~scan; // [R2]
    // Ready only counts once the programmed wait states have run out.
    wire ready_ok = (ws_set == `EBSC_WS_NONE) | ready_s2; // [R13]
    wire finish = (state == ST_ACT) & (ws_cnt == `EBSC_WS_NONE) & ready_ok; // [R12]
    wire [2:0] sp_n = space_dec(i_req_space); // [R14]

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            ws_cnt <= `EBSC_WS_NONE;
            ws_set <= `EBSC_WS_NONE;
            cur_write <= 1'b0;
            fin_pipe <= 2'b00;
        end
        else
        begin
            fin_pipe <= {fin_pipe[0], finish};
            case (state)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        state <= ST_ACT;
                        ws_cnt <= i_wait_state_control;
                        ws_set <= i_wait_state_control;
                        cur_write <= i_req_write;
                    end
                end
                ST_ACT:
                begin
                    if (ws_cnt != `EBSC_WS_NONE)
                    begin
                        ws_cnt <= ws_cnt - 1'b1;
                    end
                    else if (finish)
                    begin
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------
    // Float and scan control
    // --------------------------------------------------
    // Float only drops the enables, so the strobe sequence keeps
    // running and an access cut by a float still ends cleanly.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_strobe_oe <= 1'b1;
            o_addr_oe <= 1'b0;
            o_port_c_bit_zero_oe <= 1'b0; // [R11]
            o_scan_mode <= 1'b0;
        end
        else
        begin
            o_scan_mode <= scan; // [R1]
            o_strobe_oe <= ~float_cond; // [R10]
            o_addr_oe <= ~float_cond;
            o_port_c_bit_zero_oe <= i_port_c_bit_zero_wr_mode & ~float_cond; // [R11]
        end
    end

    // --------------------------------------------------
    // Core status
    // --------------------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= {DW{1'b0}};
        end
        else
        begin
            o_busy <= accept | (state == ST_ACT & ~finish) | finish | fin_pipe[0];
            o_done <= fin_pipe[1];
            // Read data lags the bus by the two synchroniser stages
            if (fin_pipe[1] & ~cur_write)
            begin
                o_rdata <= din_s2;
            end
        end
    end

    // --------------------------------------------------
    // Address and write data
    // --------------------------------------------------
    // Address pins hold the last address between cycles.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_addr <= {AW{1'b0}};
            o_data_out <= {DW{1'b0}};
        end
        else if (accept)
        begin
            o_addr <= i_req_addr;
            o_data_out <= i_req_wdata;
        end
    end

    // --------------------------------------------------
    // Registered bus strobes
    // --------------------------------------------------
    // Strobes return to idle on the finishing edge, so a new access
    // always sees at least one idle cycle between cycles.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_program_space_strobe_n <= `EBSC_STROBE_IDLE; // [R15]
            o_data_space_strobe_n <= `EBSC_STROBE_IDLE;
            o_io_space_strobe_n <= `EBSC_STROBE_IDLE;
            o_rw <= `EBSC_RW_IDLE;
            o_wr <= ~`EBSC_RW_IDLE;
            o_rd_n <= `EBSC_STROBE_IDLE;
            o_we_n <= `EBSC_STROBE_IDLE;
            o_external_access_strobe_n <= `EBSC_STROBE_IDLE;
            o_data_oe <= 1'b0;
        end
        else
        begin
            if (accept)
            begin
                o_program_space_strobe_n <= sp_n[0]; // [R3]
                o_data_space_strobe_n <= sp_n[1]; // [R3]
                o_io_space_strobe_n <= sp_n[2]; // [R3]
                o_rw <= ~i_req_write; // [R4]
                o_wr <= i_req_write; // [R5]
                o_rd_n <= i_req_write; // [R6]
                o_we_n <= ~i_req_write; // [R8]
                o_data_oe <= i_req_write & ~float_cond; // [R7]
                o_external_access_strobe_n <= 1'b0; // [R9]
            end
            else if (finish)
            begin
                o_program_space_strobe_n <= `EBSC_STROBE_IDLE;
                o_data_space_strobe_n <= `EBSC_STROBE_IDLE;
                o_io_space_strobe_n <= `EBSC_STROBE_IDLE;
                o_rw <= `EBSC_RW_IDLE; // [R4]
                o_wr <= ~`EBSC_RW_IDLE; // [R5]
                o_rd_n <= `EBSC_STROBE_IDLE;
                o_we_n <= `EBSC_STROBE_IDLE;
                o_data_oe <= 1'b0;
                o_external_access_strobe_n <= `EBSC_STROBE_IDLE;
            end
            else if (float_cond)
            begin
                o_data_oe <= 1'b0;
            end
        end
    end

endmodule // ebsc_top

//--- ebsc_assertions.sv
// Checker of the strobe controller's bus pins.
// Assumes it is bound onto ebsc_top and sees only its ports.
`timescale 1ns/1ps
module ebsc_assertions (
    input wire i_clk,
    input wire i_rst_n,
    input wire o_busy,
    input wire o_data_oe,
    input wire o_program_space_strobe_n,
    input wire o_data_space_strobe_n,
    input wire o_io_space_strobe_n,
    input wire o_rw,
    input wire o_wr,
    input wire o_port_c_bit_zero_oe,
    input wire o_rd_n,
    input wire o_we_n,
    input wire o_external_access_strobe_n,
    input wire o_strobe_oe
);
    wire [2:0] sp = {o_program_space_strobe_n, o_data_space_strobe_n, o_io_space_strobe_n};
    wire stb_n = o_external_access_strobe_n;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_one_space: assert property ($countones(~sp) <= 1)
        else $error("two space strobes low");
    a_wr_inverse: assert property (o_wr == !o_rw)
        else $error("write qualifier not inverse");
    a_read_strobe: assert property (!o_rd_n |-> o_rw && o_we_n && !stb_n)
        else $error("read strobe outside read cycle");
    a_write_strobe: assert property (!o_we_n |-> !o_rw && o_rd_n && !stb_n)
        else $error("write strobe outside write cycle");
    a_space_cycle: assert property (sp != 3'h7 |-> !stb_n)
        else $error("space strobe without bus cycle");
    a_cycle_busy: assert property (!stb_n |-> o_busy)
        else $error("bus cycle while idle");
    a_data_drive: assert property (o_data_oe |-> !o_we_n)
        else $error("data driven without write strobe");
    a_reset_idle: assert property ($rose(i_rst_n) |-> sp == 3'h7 && o_rw && stb_n && !o_port_c_bit_zero_oe)
        else $error("outputs not idle after reset");
endmodule // ebsc_assertions
bind ebsc_top ebsc_assertions u_chk (.*);

//--- ebsc_mem_model.sv
// External memory model on the strobe controller's pins.
// Assumes 16 words; ready has a pull-up, so it idles high.
`timescale 1ns/1ps
module ebsc_mem_model (
    input wire i_clk,
    input wire i_slow,
    input wire i_rd_n,
    input wire i_we_n,
    input wire i_stb_n,
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    output reg [15:0] o_data,
    output reg o_ready
);
    reg [15:0] mem [0:15];
    integer n = 0;
    reg [15:0] cyc = 16'h0000;
    always @(posedge i_clk)
    begin
        if (!i_we_n)
            mem[i_addr[3:0]] <= i_wdata;
        n <= i_stb_n ? 0 : n + 1;
        cyc <= cyc + 16'h0001;
    end
    // Released bus shows a moving pattern, not stale data
    always @*
    begin
        o_data = !i_rd_n ? mem[i_addr[3:0]] : ~cyc;
        o_ready = !(i_slow && !i_stb_n && n < 3);
    end
endmodule // ebsc_mem_model

//--- tb_external_bus_strobe_control.sv
// Self-checking bench of the strobe controller.
// Assumes the memory model answers on the far side.
`timescale 1ns/1ps
module tb_external_bus_strobe_control;
    reg clk = 0, rst_n = 0, req = 0, wr = 0, mode = 0, trst = 0, emulator_line_zero = 1, off = 1, slow = 0, mon = 0;
    reg [1:0] sp = 0;
    reg [15:0] addr = 0, wd = 0;
    reg [2:0] ws = 0;
    reg [6:0] seen = 0;
    wire [15:0] din, rdata, a, dout;
    wire rdy, busy, done, scan, aoe, doe, ps_n, ds_n, is_n, rw, wro, poe, rd_n, we_n, stb_n, soe;
    integer num_errors = 0, comparisons = 0, cyc = 0, n, i, k;
    initial forever #50 clk = ~clk;
    ebsc_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_req_space(sp), .i_req_write(wr),
        .i_req_addr(addr), .i_req_wdata(wd), .i_wait_state_control(ws), .i_port_c_bit_zero_wr_mode(mode),
        .i_ready(rdy), .i_test_reset(trst), .i_emulator_line_zero(emulator_line_zero), .i_emulator_line_one_output_off(off),
        .i_data_in(din), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_scan_mode(scan), .o_addr(a),
        .o_addr_oe(aoe), .o_data_out(dout), .o_data_oe(doe), .o_program_space_strobe_n(ps_n),
        .o_data_space_strobe_n(ds_n), .o_io_space_strobe_n(is_n), .o_rw(rw), .o_wr(wro),
        .o_port_c_bit_zero_oe(poe), .o_rd_n(rd_n), .o_we_n(we_n), .o_external_access_strobe_n(stb_n),
        .o_strobe_oe(soe));
    ebsc_mem_model mem (.i_clk(clk), .i_slow(slow), .i_rd_n(rd_n), .i_we_n(we_n), .i_stb_n(stb_n),
        .i_addr(a), .i_wdata(dout), .o_data(din), .o_ready(rdy));
    task give_verdict;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // Ceiling far above the fewer than two hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (!mon)
            seen <= 7'h00;
        else
            seen <= seen | {~{ps_n, ds_n, is_n, rd_n, we_n, stb_n}, doe};
        if (cyc > 20000)
        begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end
    task check(input [31:0] s, input [31:0] e);
    begin
        comparisons = comparisons + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    end
    endtask
    task acc(input [1:0] s, input w, input [2:0] q, input [15:0] d);
    begin
        @(posedge clk);
        #10;
        sp = s;
        wr = w;
        ws = q;
        wd = d;
        addr = {12'h000, d[3:0]};
        req = 1;
        mon = 1;
        @(posedge clk);
        #10;
        req = 0;
        n = 0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #10 n = n + 1;
        end
        mon = 0;
        check(done, 1'b1);
        check(seen, {s == 0, s == 1, s == 2, !w, w, 1'b1, w});
        if (!w)
            check(rdata, d);
    end
    endtask
    task t_spaces;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            acc(i[2:1], 1'b1, {2'b00, i[0]}, 16'h00A0 + i[15:0]);
            check(n, (i & 1) + 3);
            acc(i[2:1], 1'b0, {2'b00, i[0]}, 16'h00A0 + i[15:0]);
        end
        $display("spaces test done");
    end
    endtask
    task t_ready;
    begin
        slow = 1;
        acc(1, 1, 2, 16'h5A5E);
        check(n > 5, 1);
        acc(1, 0, 2, 16'h5A5E);
        check(n > 5, 1);
        acc(1, 0, 0, 16'h5A5E);
        check(n, 3);
        slow = 0;
        $display("ready test done");
    end
    endtask
    task t_float;
    begin
        off = 0;
        repeat (4) @(posedge clk);
        #10 check({soe, aoe, doe, poe}, 0);
        emulator_line_zero = 0;
        repeat (4) @(posedge clk);
        #10 check({soe, aoe}, 2'h3);
        emulator_line_zero = 1;
        trst = 1;
        repeat (4) @(posedge clk);
        #10 req = 1;
        repeat (2) @(posedge clk);
        #10 check({soe, aoe, scan, busy}, 4'hE);
        req = 0;
        trst = 0;
        off = 1;
        mode = 1;
        repeat (4) @(posedge clk);
        #10 check({soe, scan, poe}, 3'h5);
        mode = 0;
        acc(2, 0, 0, 16'h00A4);
        $display("float test done");
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #10 check({ps_n, ds_n, is_n, rw, wro, stb_n, poe}, 7'h7A);
        rst_n = 1;
        t_spaces;
        t_ready;
        t_float;
        give_verdict;
    end
endmodule // tb_external_bus_strobe_control
